// *** core/drs_pkg.sv ***
// constants, register map and types shared by the ramp select / coast stop block
package drs_pkg;

   localparam int DRS_NUM_IN = 7;
   localparam int DRS_FREQ_W = 16;
   localparam int DRS_RATE_W = 24;
   localparam int DRS_ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] DRS_OFS_CTRL = 8'h00;
   localparam logic [7:0] DRS_OFS_FUNC_A = 8'h04;
   localparam logic [7:0] DRS_OFS_FUNC_B = 8'h08;
   localparam logic [7:0] DRS_OFS_POL = 8'h0C;
   localparam logic [7:0] DRS_OFS_ACC1 = 8'h10;
   localparam logic [7:0] DRS_OFS_DEC1 = 8'h14;
   localparam logic [7:0] DRS_OFS_ACC2 = 8'h18;
   localparam logic [7:0] DRS_OFS_DEC2 = 8'h1C;
   localparam logic [7:0] DRS_OFS_TARGET = 8'h20;
   localparam logic [7:0] DRS_OFS_DELAY = 8'h24;
   localparam logic [7:0] DRS_OFS_STATUS = 8'h28;

   // control and status register fields
   localparam int DRS_CTRL_RUN_BIT = 0;
   localparam int DRS_CTRL_MODE_BIT = 1;
   localparam int DRS_CTRL_METH_LSB = 2;
   localparam int DRS_STAT_DRIVE_BIT = 16;
   localparam int DRS_STAT_PROF_BIT = 17;
   localparam int DRS_STAT_COAST_BIT = 18;
   localparam int DRS_STAT_STATE_LSB = 19;

   // terminal function codes and method encoding
   localparam logic [7:0] DRS_FUNC_PROFILE = 8'h09;
   localparam logic [7:0] DRS_FUNC_COAST = 8'h0B;
   localparam logic [1:0] DRS_METHOD_TERMINAL = 2'h0;

   // reset values
   localparam logic [31:0] DRS_RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] DRS_RST_FUNC_A = 32'hFFFF_0B09;
   localparam logic [31:0] DRS_RST_FUNC_B = 32'hFFFF_FFFF;
   localparam logic [6:0] DRS_RST_POL = 7'h00;
   localparam logic [23:0] DRS_RST_RATE = 24'h001388;
   localparam logic [15:0] DRS_RST_TARGET = 16'h0000;
   localparam logic [15:0] DRS_RST_DELAY = 16'h0000;

   // restart delay unit and clock
   localparam int DRS_CLK_HZ = 50_000_000;
   localparam int DRS_DELAY_UNIT_MS = 100;
   localparam int DRS_DELAY_TICK_CYC = DRS_CLK_HZ / 1000 * DRS_DELAY_UNIT_MS;

   localparam logic [1:0] DRS_RESP_OKAY = 2'h0;
   localparam logic [1:0] DRS_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DRS_ST_STOP = 2'b00,
      DRS_ST_RUN = 2'b01,
      DRS_ST_COAST = 2'b10,
      DRS_ST_DELAY = 2'b11
   } drs_state_t;

endpackage

// *** core/drs_ramp_if.sv ***
// carrier between the sequencer and the frequency ramp generator
`timescale 1ns/100ps
interface drs_ramp_if #(parameter int FREQ_W = 16, parameter int RATE_W = 24);
   logic drive_en;
   logic load;
   logic [FREQ_W-1:0] load_freq;
   logic [FREQ_W-1:0] target;
   logic [RATE_W-1:0] accel_rate;
   logic [RATE_W-1:0] decel_rate;
   logic [FREQ_W-1:0] freq;

   modport ctrl (output drive_en, load, load_freq, target, accel_rate, decel_rate,
      input freq);
   modport ramp (input drive_en, load, load_freq, target, accel_rate, decel_rate,
      output freq);
endinterface

// *** core/drs_in_cond.sv ***
// input terminal synchroniser, polarity and function decode
`timescale 1ns/100ps
module drs_in_cond import drs_pkg::*; #(
   parameter int NUM_IN = 7
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [NUM_IN-1:0] term_pin,
   input wire logic [NUM_IN*8-1:0] term_func,
   input wire logic [NUM_IN-1:0] term_pol,
   output logic profile_sel_active,
   output logic coast_active
);
   typedef struct packed {
      logic [NUM_IN-1:0] sync1;
      logic [NUM_IN-1:0] sync2;
      logic prof;
      logic coast;
   } drs_cond_t;

   drs_cond_t s;
   drs_cond_t next_s;

   always_comb begin
      logic [NUM_IN-1:0] lvl;
      lvl = '0;
      next_s = s;
      next_s.sync1 = term_pin;
      next_s.sync2 = s.sync1;
      lvl = s.sync2 ^ term_pol; // active low terminals invert here [R9]
      next_s.prof = 1'b0;
      next_s.coast = 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
         if (lvl[i] && term_func[i*8 +: 8] == DRS_FUNC_PROFILE) begin
            next_s.prof = 1'b1; // [R1]
         end
         if (lvl[i] && term_func[i*8 +: 8] == DRS_FUNC_COAST) begin
            next_s.coast = 1'b1; // [R5]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign profile_sel_active = s.prof;
   assign coast_active = s.coast;
endmodule

// *** core/drs_ramp.sv ***
// output frequency ramp: one step per rate period toward the target
`timescale 1ns/100ps
module drs_ramp #(
   parameter int FREQ_W = 16,
   parameter int RATE_W = 24
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   drs_ramp_if.ramp rif
);
   typedef struct packed {
      logic [FREQ_W-1:0] freq;
      logic [RATE_W-1:0] timer;
   } drs_ramp_t;

   drs_ramp_t s;
   drs_ramp_t next_s;

   always_comb begin
      logic [RATE_W-1:0] rate;
      rate = '0;
      next_s = s;
      if (!rif.drive_en) begin
         next_s.freq = '0; // output removed while coasting or stopped [R5]
         next_s.timer = '0;
      end else if (rif.load) begin
         next_s.freq = rif.load_freq; // [R7]
         next_s.timer = '0;
      end else if (s.freq != rif.target) begin
         // rate is read live, so a profile change retimes the ramp in flight
         // while the frequency value itself never jumps [R3] [R10]
         rate = (s.freq < rif.target) ? rif.accel_rate : rif.decel_rate;
         if (s.timer >= rate) begin
            next_s.timer = '0;
            if (s.freq < rif.target) begin
               next_s.freq = s.freq + 1'b1;
            end else begin
               next_s.freq = s.freq - 1'b1;
            end
         end else begin
            next_s.timer = s.timer + 1'b1;
         end
      end else begin
         next_s.timer = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rif.freq = s.freq;
endmodule

// *** core/drs_top.sv ***
// ramp profile select and coast stop sequencer with AXI4-Lite registers
// What this block does
// [R1] An active terminal coded 09 makes the ramp use the second accel and decel times.
// [R2] When that terminal goes inactive the ramp returns to the first accel and decel times.
// [R3] A profile change during an acceleration retimes it at once, without waiting.
// [R4] The profile terminal only acts while the switch method setting is 00.
// [R5] An active terminal coded 11 removes the drive at once so the motor coasts.
// [R6] On coast release the drive resumes only if the run command is still on.
// [R7] The restart mode picks restart from 0 Hz or from the present motor speed.
// [R8] A programmable delay precedes the restart after coast release; zero means no wait.
// [R9] Each terminal has a polarity bit so coast stop can be active low.
// [R10] A profile change keeps the present frequency and changes only the rate.
`timescale 1ns/100ps
module drs_top import drs_pkg::*; #(
   parameter int DELAY_TICK_CYCLES = DRS_DELAY_TICK_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DRS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [DRS_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [DRS_NUM_IN-1:0] term_pin,
   input wire logic [DRS_FREQ_W-1:0] motor_speed,
   output logic [DRS_FREQ_W-1:0] out_freq,
   output logic out_drive_en
);
   typedef struct packed {
      // bus side
      logic aw_got;
      logic w_got;
      logic [DRS_ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      // registers
      logic [31:0] ctrl;
      logic [31:0] func_a;
      logic [31:0] func_b;
      logic [6:0] pol;
      logic [23:0] acc1;
      logic [23:0] dec1;
      logic [23:0] acc2;
      logic [23:0] dec2;
      logic [15:0] target;
      logic [15:0] delay;
      // sequencer
      drs_state_t state;
      logic drive_en;
      logic load;
      logic [15:0] load_freq;
      logic [15:0] delay_left;
      logic [31:0] tick;
   } drs_top_t;

   drs_top_t s;
   drs_top_t next_s;

   logic prof_in;
   logic coast_in;
   logic profile2;
   logic run_cmd;

   drs_ramp_if #(.FREQ_W(DRS_FREQ_W), .RATE_W(DRS_RATE_W)) rif ();

   drs_in_cond #(.NUM_IN(DRS_NUM_IN)) u_cond (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .term_pin(term_pin),
      .term_func({s.func_b[23:0], s.func_a}),
      .term_pol(s.pol), // [R9]
      .profile_sel_active(prof_in),
      .coast_active(coast_in)
   );

   drs_ramp #(.FREQ_W(DRS_FREQ_W), .RATE_W(DRS_RATE_W)) u_ramp (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .rif(rif.ramp)
   );

   function automatic logic [31:0] drs_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // the profile terminal is ignored under any other switch method [R4]
   assign profile2 = (s.ctrl[DRS_CTRL_METH_LSB +: 2] == DRS_METHOD_TERMINAL) && prof_in;
   assign run_cmd = s.ctrl[DRS_CTRL_RUN_BIT];

   assign rif.drive_en = s.drive_en;
   assign rif.load = s.load;
   assign rif.load_freq = s.load_freq;
   assign rif.target = run_cmd ? s.target : '0;
   assign rif.accel_rate = profile2 ? s.acc2 : s.acc1; // [R1] [R2] [R3]
   assign rif.decel_rate = profile2 ? s.dec2 : s.dec1; // [R1] [R2]

   always_comb begin
      logic [31:0] rd;
      logic [31:0] m;
      logic hit;
      logic [15:0] restart_freq;
      rd = '0;
      m = '0;
      hit = 1'b1;
      restart_freq = '0;
      next_s = s;
      next_s.load = 1'b0;

      // write: address and data taken in either order, answer after both
      if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.aw_got && s.w_got) begin
         m = drs_merge(32'h0000_0000, s.wdata, s.wstrb);
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = DRS_RESP_OKAY;
         if (s.awaddr == DRS_OFS_CTRL) begin
            next_s.ctrl = drs_merge(s.ctrl, s.wdata, s.wstrb) & 32'h0000_000F;
         end else if (s.awaddr == DRS_OFS_FUNC_A) begin
            next_s.func_a = drs_merge(s.func_a, s.wdata, s.wstrb);
         end else if (s.awaddr == DRS_OFS_FUNC_B) begin
            next_s.func_b = drs_merge(s.func_b, s.wdata, s.wstrb);
         end else if (s.awaddr == DRS_OFS_POL) begin
            m = drs_merge({25'h0, s.pol}, s.wdata, s.wstrb);
            next_s.pol = m[6:0];
         end else if (s.awaddr == DRS_OFS_ACC1) begin
            m = drs_merge({8'h00, s.acc1}, s.wdata, s.wstrb);
            next_s.acc1 = m[23:0];
         end else if (s.awaddr == DRS_OFS_DEC1) begin
            m = drs_merge({8'h00, s.dec1}, s.wdata, s.wstrb);
            next_s.dec1 = m[23:0];
         end else if (s.awaddr == DRS_OFS_ACC2) begin
            m = drs_merge({8'h00, s.acc2}, s.wdata, s.wstrb);
            next_s.acc2 = m[23:0];
         end else if (s.awaddr == DRS_OFS_DEC2) begin
            m = drs_merge({8'h00, s.dec2}, s.wdata, s.wstrb);
            next_s.dec2 = m[23:0];
         end else if (s.awaddr == DRS_OFS_TARGET) begin
            m = drs_merge({16'h0000, s.target}, s.wdata, s.wstrb);
            next_s.target = m[15:0];
         end else if (s.awaddr == DRS_OFS_DELAY) begin
            m = drs_merge({16'h0000, s.delay}, s.wdata, s.wstrb);
            next_s.delay = m[15:0];
         end else if (s.awaddr == DRS_OFS_STATUS) begin
            next_s.bresp = DRS_RESP_OKAY; // read only, write dropped
         end else begin
            next_s.bresp = DRS_RESP_SLVERR;
         end
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // read
      if (s_axi_arvalid && !s.rvalid) begin
         if (s_axi_araddr == DRS_OFS_CTRL) begin
            rd = s.ctrl;
         end else if (s_axi_araddr == DRS_OFS_FUNC_A) begin
            rd = s.func_a;
         end else if (s_axi_araddr == DRS_OFS_FUNC_B) begin
            rd = s.func_b;
         end else if (s_axi_araddr == DRS_OFS_POL) begin
            rd = {25'h0, s.pol};
         end else if (s_axi_araddr == DRS_OFS_ACC1) begin
            rd = {8'h00, s.acc1};
         end else if (s_axi_araddr == DRS_OFS_DEC1) begin
            rd = {8'h00, s.dec1};
         end else if (s_axi_araddr == DRS_OFS_ACC2) begin
            rd = {8'h00, s.acc2};
         end else if (s_axi_araddr == DRS_OFS_DEC2) begin
            rd = {8'h00, s.dec2};
         end else if (s_axi_araddr == DRS_OFS_TARGET) begin
            rd = {16'h0000, s.target};
         end else if (s_axi_araddr == DRS_OFS_DELAY) begin
            rd = {16'h0000, s.delay};
         end else if (s_axi_araddr == DRS_OFS_STATUS) begin
            rd = {11'h000, s.state, coast_in, profile2, s.drive_en, rif.freq};
         end else begin
            hit = 1'b0;
         end
         next_s.rvalid = 1'b1;
         next_s.rdata = rd;
         next_s.rresp = hit ? DRS_RESP_OKAY : DRS_RESP_SLVERR;
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end

      // sequencer
      restart_freq = s.ctrl[DRS_CTRL_MODE_BIT] ? motor_speed : '0; // [R7]
      case (s.state)
         DRS_ST_STOP: begin
            next_s.drive_en = 1'b0;
            if (coast_in) begin
               next_s.state = DRS_ST_COAST;
            end else if (run_cmd) begin
               next_s.state = DRS_ST_RUN;
               next_s.drive_en = 1'b1;
               next_s.load = 1'b1;
               next_s.load_freq = '0;
            end
         end
         DRS_ST_RUN: begin
            if (coast_in) begin
               next_s.state = DRS_ST_COAST; // drive dropped next edge [R5]
               next_s.drive_en = 1'b0;
            end else if (!run_cmd && rif.freq == '0) begin
               next_s.state = DRS_ST_STOP;
               next_s.drive_en = 1'b0;
            end
         end
         DRS_ST_COAST: begin
            next_s.drive_en = 1'b0; // [R5]
            if (!coast_in) begin
               if (!run_cmd) begin
                  next_s.state = DRS_ST_STOP; // [R6]
               end else if (s.delay == '0) begin
                  next_s.state = DRS_ST_RUN; // zero delay skips the wait [R8]
                  next_s.drive_en = 1'b1;
                  next_s.load = 1'b1;
                  next_s.load_freq = restart_freq; // [R6] [R7]
               end else begin
                  next_s.state = DRS_ST_DELAY; // [R8]
                  next_s.delay_left = s.delay;
                  next_s.tick = '0;
               end
            end
         end
         DRS_ST_DELAY: begin
            next_s.drive_en = 1'b0;
            if (coast_in) begin
               next_s.state = DRS_ST_COAST;
            end else if (!run_cmd) begin
               next_s.state = DRS_ST_STOP; // [R6]
            end else if (s.tick == 32'(DELAY_TICK_CYCLES - 1)) begin
               next_s.tick = '0;
               if (s.delay_left == 16'h0001) begin
                  // speed sampled at the end of the wait, not at release [R7] [R8]
                  next_s.state = DRS_ST_RUN;
                  next_s.drive_en = 1'b1;
                  next_s.load = 1'b1;
                  next_s.load_freq = restart_freq;
               end else begin
                  next_s.delay_left = s.delay_left - 1'b1;
               end
            end else begin
               next_s.tick = s.tick + 1'b1;
            end
         end
         default: begin
            next_s.state = DRS_ST_STOP;
            next_s.drive_en = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.ctrl <= DRS_RST_CTRL;
         s.func_a <= DRS_RST_FUNC_A;
         s.func_b <= DRS_RST_FUNC_B;
         s.pol <= DRS_RST_POL;
         s.acc1 <= DRS_RST_RATE;
         s.dec1 <= DRS_RST_RATE;
         s.acc2 <= DRS_RST_RATE;
         s.dec2 <= DRS_RST_RATE;
         s.target <= DRS_RST_TARGET;
         s.delay <= DRS_RST_DELAY;
         s.state <= DRS_ST_STOP;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready = !s.aw_got && !s.bvalid;
   assign s_axi_wready = !s.w_got && !s.bvalid;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign out_freq = rif.freq;
   assign out_drive_en = s.drive_en;
endmodule

// *** bench/drs_properties.sv ***
// port-level assertions for the ramp select and coast stop block
`timescale 1ns/100ps
module drs_properties import drs_pkg::*; (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [DRS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [DRS_NUM_IN-1:0] term_pin,
   input wire logic [DRS_FREQ_W-1:0] motor_speed,
   input wire logic [DRS_FREQ_W-1:0] out_freq,
   input wire logic out_drive_en
);
   logic run_r, mode_r, pol1, delay_nz, coast_act, wr;
   // settings shadow; assumes address and data are taken in one cycle
   assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         run_r <= 1'b0;
         mode_r <= 1'b0;
         pol1 <= 1'b0;
         delay_nz <= 1'b0;
      end else if (wr) begin
         if (s_axi_awaddr == DRS_OFS_CTRL) begin
            run_r <= s_axi_wdata[DRS_CTRL_RUN_BIT];
            mode_r <= s_axi_wdata[DRS_CTRL_MODE_BIT];
         end
         if (s_axi_awaddr == DRS_OFS_POL) pol1 <= s_axi_wdata[1];
         if (s_axi_awaddr == DRS_OFS_DELAY) delay_nz <= |s_axi_wdata[15:0];
      end
   end
   // terminal 1 holds the coast function in the reset function map
   assign coast_act = term_pin[1] ^ pol1;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_coast_cuts_drive: assert property (coast_act [*6] |-> !out_drive_en)
      else $error("drive on during coast");
   a_coast_zero_freq: assert property ($rose(coast_act) |-> ##[1:7] out_freq == 16'h0000)
      else $error("frequency not cleared on coast");
   a_run_off_idle: assert property ($fell(coast_act) && !run_r |-> !out_drive_en [*8])
      else $error("restart without run command");
   a_resume_on_run: assert property ($fell(coast_act) && run_r && !delay_nz
      |-> ##[1:8] out_drive_en) else $error("no restart after release");
   a_delay_holds_off: assert property ($fell(coast_act) && run_r && delay_nz
      |-> !out_drive_en [*8]) else $error("restart before delay");
   a_restart_zero: assert property ($rose(out_drive_en) && !mode_r
      |-> out_freq <= 16'h0001) else $error("restart not from zero");
   a_restart_speed: assert property ($rose(out_drive_en) && mode_r
      |-> ##1 (out_freq + 16'h0001 >= motor_speed && out_freq <= motor_speed + 16'h0001))
      else $error("restart not speed matched");
   a_freq_no_jump: assert property (out_drive_en && $past(out_drive_en, 2)
      |-> (out_freq - $past(out_freq)) inside {16'h0000, 16'h0001, 16'hFFFF})
      else $error("output frequency stepped");
   c_coast_delay: cover property ($fell(coast_act) && run_r && delay_nz);
   c_speed_restart: cover property ($rose(out_drive_en) && mode_r);
   c_profile_run: cover property (term_pin[0] && out_drive_en);
endmodule

bind drs_top drs_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_wdata(s_axi_wdata), .term_pin(term_pin), .motor_speed(motor_speed),
   .out_freq(out_freq), .out_drive_en(out_drive_en));

// *** bench/drs_switches.sv ***
// terminal switch bank: wanted function levels mapped onto pin levels
`timescale 1ns/100ps
module drs_switches (
   input wire logic prof_on,
   input wire logic coast_on,
   input wire logic [6:0] pol,
   output logic [6:0] term_pin
);
   // a set polarity bit models a normally closed contact: open means asserted
   assign term_pin = {5'h00, coast_on, prof_on} ^ pol;
endmodule

// *** bench/testbench.sv ***
// self-checking bench for ramp profile select and coast stop
`timescale 1ns/100ps
`define DRS_CHK(act, exp, msg) \
   begin tests_run++; if ((act) !== (exp)) note_fail(msg); end
module testbench import drs_pkg::*;;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, drive_en, prof_on = 1'b0, coast_on = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [1:0] bresp, rresp;
   logic [6:0] pol = 7'h00, term_pin;
   logic [15:0] motor_speed = 16'h0000, freq;
   int failures = 0, tests_run = 0;

   drs_switches u_sw (.prof_on(prof_on), .coast_on(coast_on), .pol(pol), .term_pin(term_pin));
   // short delay tick: one restart delay unit is 10 cycles here
   drs_top #(.DELAY_TICK_CYCLES(10)) DUT (.clk_sys(clk_sys), .arst_n(arst_n),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .term_pin(term_pin), .motor_speed(motor_speed), .out_freq(freq), .out_drive_en(drive_en));

   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic note_fail(input string m);
      failures++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung write
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // cycles between frequency steps; two steps skipped so a retimed step is whole
   task automatic step_gap(output int n);
      logic [15:0] f;
      @(negedge clk_sys);
      for (int k = 0; k < 3; k++) begin
         n = 0;
         f = freq;
         while (freq === f && n < 500) begin
            @(negedge clk_sys);
            n++;
         end
      end
   endtask

   task automatic wait_drive(input int lim);
      int n;
      n = 0;
      while (drive_en !== 1'b1 && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
   endtask

   task automatic test_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(DRS_OFS_FUNC_A, d, r);
      `DRS_CHK(d[15:0], 16'h0B09, "terminal function codes")
      axi_rd(8'h30, d, r);
      `DRS_CHK(r, DRS_RESP_SLVERR, "unmapped read answer")
      axi_wr(8'h30, 32'h0000_0000);
      `DRS_CHK(bresp, DRS_RESP_SLVERR, "unmapped write answer")
      $display("done: regs");
   endtask

   task automatic test_profile();
      int n;
      axi_wr(DRS_OFS_ACC1, 32'h0000_0013);
      axi_wr(DRS_OFS_ACC2, 32'h0000_0003);
      axi_wr(DRS_OFS_DEC1, 32'h0000_001D);
      axi_wr(DRS_OFS_DEC2, 32'h0000_0005);
      axi_wr(DRS_OFS_TARGET, 32'h0000_0200);
      axi_wr(DRS_OFS_CTRL, 32'h0000_0001);
      step_gap(n);
      `DRS_CHK(n, 20, "first accel rate")
      @(posedge clk_sys);
      prof_on <= 1'b1;
      step_gap(n);
      `DRS_CHK(n, 4, "accel not retimed")
      axi_wr(DRS_OFS_CTRL, 32'h0000_0005);
      step_gap(n);
      `DRS_CHK(n, 20, "profile acted in other method")
      axi_wr(DRS_OFS_CTRL, 32'h0000_0001);
      repeat (100) @(negedge clk_sys);
      step_gap(n);
      `DRS_CHK(n, 4, "second accel rate")
      @(posedge clk_sys);
      prof_on <= 1'b0;
      step_gap(n);
      `DRS_CHK(n, 20, "first rate not restored")
      axi_wr(DRS_OFS_TARGET, 32'h0000_0000);
      step_gap(n);
      `DRS_CHK(n, 30, "first decel rate")
      @(posedge clk_sys);
      prof_on <= 1'b1;
      step_gap(n);
      `DRS_CHK(n, 6, "second decel rate")
      axi_wr(DRS_OFS_TARGET, 32'h0000_0040);
      $display("done: profile");
   endtask

   task automatic test_coast_zero();
      axi_wr(DRS_OFS_DELAY, 32'h0000_0002);
      @(posedge clk_sys);
      coast_on <= 1'b1;
      repeat (8) @(negedge clk_sys);
      `DRS_CHK(drive_en, 1'b0, "drive on during coast")
      `DRS_CHK(freq, 16'h0000, "frequency kept in coast")
      @(posedge clk_sys);
      coast_on <= 1'b0;
      repeat (15) @(negedge clk_sys);
      `DRS_CHK(drive_en, 1'b0, "restart before delay")
      wait_drive(15);
      `DRS_CHK(drive_en, 1'b1, "no restart after delay")
      `DRS_CHK(freq <= 16'h0001, 1'b1, "restart not from zero")
      $display("done: coast zero");
   endtask

   task automatic test_coast_pol();
      @(posedge clk_sys);
      motor_speed <= 16'h012C;
      axi_wr(DRS_OFS_CTRL, 32'h0000_0003);
      axi_wr(DRS_OFS_DELAY, 32'h0000_0000);
      // open contact on an active-low terminal means coast
      axi_wr(DRS_OFS_POL, 32'h0000_0002);
      repeat (8) @(negedge clk_sys);
      `DRS_CHK(drive_en, 1'b0, "active low coast ignored")
      @(posedge clk_sys);
      pol <= 7'h02;
      wait_drive(10);
      `DRS_CHK(drive_en, 1'b1, "no restart with run on")
      @(negedge clk_sys);
      `DRS_CHK(freq >= 16'h012B && freq <= 16'h012D, 1'b1, "not speed matched")
      $display("done: coast speed");
   endtask

   task automatic test_run_off();
      @(posedge clk_sys);
      coast_on <= 1'b1;
      repeat (8) @(negedge clk_sys);
      axi_wr(DRS_OFS_CTRL, 32'h0000_0000);
      @(posedge clk_sys);
      coast_on <= 1'b0;
      repeat (30) @(negedge clk_sys);
      `DRS_CHK(drive_en, 1'b0, "restart without run")
      $display("done: run off");
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      test_regs();
      test_profile();
      test_coast_zero();
      test_coast_pol();
      test_run_off();
      finish_test();
   end

   // whole run is under a thousand cycles; this is 20000 cycles, over twenty times that
   initial begin
      #400000;
      note_fail("watchdog expired");
      finish_test();
   end
endmodule
